// ---- hdl/asr_pkg.sv ----
// Constants, register map and types of the asynchronous serial receiver
// Functional notes
// R1: A falling edge on the idle line starts a character; start bit is low.
// R2: Half a bit later the line must still be low, else silently abandon.
// R3: Each next bit centre is one bit later; majority vote, shift in.
// R4: Stop bit sampled one bit after last data bit; low means framing error.
// R5: After the stop bit the character moves into the receive buffer.
// R6: Reading receive data returns the oldest character and advances the buffer.
// R7: Receive flag is high while enabled with unread data; software cannot touch.
// R8: Interrupt only when receive, peripheral and global enables are all set.
// R9: Each character keeps its framing bit; status shows the oldest one.
// R10: Framing errors do not block reception nor raise an interrupt alone.
// R11: Port disable clears framing status; receive-enable clear leaves it.
// R12: Buffer holds two; a third complete character sets overrun.
// R13: During overrun buffered data stays readable, new characters are dropped.
// R14: Overrun clears only by clearing receive enable or port enable.
// R15: Nine-bit mode shifts nine bits; ninth bit kept and shown per character.
// R16: Software reads status before data since the data read advances.
// R17: Address detect in nine-bit mode keeps only ninth-bit-set characters.
// R18: Software turns address detect off before next stop bit after match.
// R19: Software sets baud, port, interrupts, nine-bit, then receive enable.
// R20: Bit recovery runs at sixteen ticks per bit; shifter once per bit.
// R21: Receiver runs only with receive enable, async mode and port enable.
// R22: Port disable idles the receiver, empties buffer, clears error flags.
package asr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_FLAG = 8'h0C;
  localparam logic [7:0] OFF_IEN = 8'h10;
  localparam logic [7:0] OFF_INTC = 8'h14;
  localparam logic [7:0] OFF_BAUD = 8'h18;
  // Control and status field positions
  localparam int B_PORT_EN = 7;
  localparam int B_NINE_SEL = 6;
  localparam int B_CONT_EN = 4;
  localparam int B_ADDR_DET = 3;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_NINTH = 0;
  localparam int B_SYNC_MODE = 4;
  localparam int B_RX_FLAG = 5;
  localparam int B_RX_IEN = 5;
  localparam int B_GLOBAL_IEN = 7;
  localparam int B_PERIPH_IEN = 6;
  // Reset values
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Oversampling: ticks per bit and vote positions inside a bit
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] VOTE_FIRST = 4'h6;
  localparam logic [3:0] VOTE_SECOND = 4'h7;
  localparam logic [3:0] VOTE_DECIDE = 4'h8;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} asr_state_t;
endpackage : asr_pkg

// ---- hdl/asr_receiver.sv ----
// Asynchronous serial receiver with APB register access
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module asr_receiver
  import asr_pkg::*;
#(
  parameter logic [7:0] BAUD_DEFAULT = BAUD_RESET
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rx_line,
  // Flags
  output logic receive_flag,
  output logic interrupt_request
);

  typedef struct packed {
    // Software control bits
    logic port_enable;
    logic nine_bit_receive_select;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic sync_mode;
    logic receive_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic global_interrupt_enable;
    logic [7:0] baud_divisor;
    // Tick divider and bit recovery
    logic [7:0] div_cnt;
    asr_state_t state;
    logic [3:0] phase;
    logic [3:0] bit_cnt;
    logic [1:0] samples;
    logic [8:0] receive_shift_register;
    logic rx_prev;
    // Two-entry buffer, overrun and bus read data
    logic [1:0] count;
    logic [1:0][9:0] entries;
    logic overrun_error_flag;
    logic [DATA_W-1:0] rdata;
  } asr_regs_t;

  asr_regs_t s;
  asr_regs_t next_s;

  // Byte-address match for one register
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Any mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_CTRL) | hit(a, OFF_MODE) | hit(a, OFF_DATA) |
             hit(a, OFF_FLAG) | hit(a, OFF_IEN) | hit(a, OFF_INTC) |
             hit(a, OFF_BAUD);
  endfunction : mapped

  // Two-of-three majority
  function automatic logic vote(input logic [1:0] a, input logic b);
    vote = (a[0] & a[1]) | (a[0] & b) | (a[1] & b);
  endfunction : vote

  // Data bits per character in the selected mode
  function automatic logic [3:0] char_bits(input logic nine);
    if (nine) begin
      char_bits = BITS_NINE;
    end else begin
      char_bits = BITS_EIGHT;
    end
  endfunction : char_bits

  // Buffer entry: framing flag, ninth bit, eight data bits
  function automatic logic [9:0] pack_entry(input logic stop_bit,
                                            input logic nine,
                                            input logic [8:0] shifted);
    logic [9:0] e;
    e[9] = ~stop_bit;
    if (nine) begin
      e[8:0] = shifted;
    end else begin
      // Eight-bit frames stop one place short of the bottom
      e[8:0] = {1'b0, shifted[8:1]};
    end
    pack_entry = e;
  endfunction : pack_entry

  // Nine-bit address mode passes only characters with the ninth bit set
  function automatic logic admitted(input logic nine, input logic detect,
                                    input logic [9:0] e);
    admitted = ~(nine & detect) | e[8];
  endfunction : admitted

  logic enabled;
  logic flag;
  logic access;
  logic [9:0] head;

  // Register strobes from the access phase
  logic wr_ctrl;
  logic wr_mode;
  logic wr_ien;
  logic wr_intc;
  logic wr_baud;
  logic rd_data;
  logic unmapped;

  // Oversampling tick, vote samples and decision point
  logic tick;
  logic sample_point;
  logic at_decide;
  logic rx_fall;

  // Receiver runs only in async mode with both enables set
  assign enabled = s.port_enable & s.continuous_receive_enable &
                   ~s.sync_mode; // R21
  assign flag = enabled & (s.count != 2'h0); // R7
  assign head = s.entries[0];
  assign access = psel & penable;
  assign wr_ctrl = access & pwrite & hit(paddr, OFF_CTRL);
  assign wr_mode = access & pwrite & hit(paddr, OFF_MODE);
  assign wr_ien = access & pwrite & hit(paddr, OFF_IEN);
  assign wr_intc = access & pwrite & hit(paddr, OFF_INTC);
  assign wr_baud = access & pwrite & hit(paddr, OFF_BAUD);
  assign rd_data = access & ~pwrite & hit(paddr, OFF_DATA);
  assign unmapped = ~mapped(paddr);
  // One tick per divisor reload; divisor zero ticks every clock
  assign tick = enabled & (s.div_cnt == 8'h00); // R20
  assign sample_point = tick & ((s.phase == VOTE_FIRST) |
                                (s.phase == VOTE_SECOND));
  assign at_decide = tick & (s.phase == VOTE_DECIDE);
  // rx_prev resets high, so reset release gives no false edge
  assign rx_fall = s.rx_prev & ~rx_line; // R1

  // Read mux; framing and ninth-bit status come from the oldest entry
  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = WORD_ZERO;
    if (hit(a, OFF_CTRL)) begin
      w[B_PORT_EN] = s.port_enable;
      w[B_NINE_SEL] = s.nine_bit_receive_select;
      w[B_CONT_EN] = s.continuous_receive_enable;
      w[B_ADDR_DET] = s.address_detect_enable;
      w[B_FRAME_ERR] = head[9]; // R9
      w[B_OVERRUN] = s.overrun_error_flag;
      w[B_NINTH] = head[8]; // R15
    end
    if (hit(a, OFF_MODE)) begin
      w[B_SYNC_MODE] = s.sync_mode;
    end
    if (hit(a, OFF_DATA)) begin
      w[7:0] = head[7:0];
    end
    if (hit(a, OFF_FLAG)) begin
      w[B_RX_FLAG] = flag;
    end
    if (hit(a, OFF_IEN)) begin
      w[B_RX_IEN] = s.receive_interrupt_enable;
    end
    if (hit(a, OFF_INTC)) begin
      w[B_GLOBAL_IEN] = s.global_interrupt_enable;
      w[B_PERIPH_IEN] = s.peripheral_interrupt_enable;
    end
    if (hit(a, OFF_BAUD)) begin
      w[7:0] = s.baud_divisor;
    end
    rd_word = w;
  endfunction : rd_word

  always_comb begin
    logic bit_val;
    logic deliver;
    logic pop;
    logic [9:0] entry;
    logic [1:0] left;
    bit_val = 1'b0;
    deliver = 1'b0;
    pop = 1'b0;
    entry = 10'h000;
    next_s = s;
    next_s.rx_prev = rx_line;

    // APB setup phase captures read data; access phase commits
    if (psel & ~penable) begin
      next_s.rdata = rd_word(paddr);
    end
    if (wr_ctrl) begin
      next_s.port_enable = pwdata[B_PORT_EN];
      next_s.nine_bit_receive_select = pwdata[B_NINE_SEL];
      next_s.continuous_receive_enable = pwdata[B_CONT_EN];
      next_s.address_detect_enable = pwdata[B_ADDR_DET];
    end
    if (wr_mode) begin
      next_s.sync_mode = pwdata[B_SYNC_MODE];
    end
    if (wr_ien) begin
      next_s.receive_interrupt_enable = pwdata[B_RX_IEN];
    end
    if (wr_intc) begin
      next_s.global_interrupt_enable = pwdata[B_GLOBAL_IEN];
      next_s.peripheral_interrupt_enable = pwdata[B_PERIPH_IEN];
    end
    if (wr_baud) begin
      next_s.baud_divisor = pwdata[7:0];
    end
    if (rd_data & (s.count != 2'h0)) begin
      pop = 1'b1; // R6
    end

    // Sixteen-per-bit tick divider
    if (!enabled || s.div_cnt == 8'h00) begin
      next_s.div_cnt = s.baud_divisor;
    end else begin
      next_s.div_cnt = s.div_cnt - 8'h01;
    end

    // Bit recovery
    if (!enabled) begin
      next_s.state = ST_IDLE; // R21
    end else begin
      if (tick) begin
        next_s.phase = s.phase + 4'h1; // R20
      end
      // Two early samples feed the vote; the line itself is the third
      if (sample_point) begin
        next_s.samples = {s.samples[0], rx_line};
      end
      bit_val = vote(s.samples, rx_line);
      unique case (s.state)
        // Idle: wait for the line to fall
        ST_IDLE: begin
          if (rx_fall) begin
            next_s.state = ST_START; // R1
            next_s.phase = 4'h0;
            next_s.bit_cnt = 4'h0;
          end
        end
        // Start: line must still be low at mid-bit
        ST_START: begin
          if (at_decide) begin
            if (bit_val) begin
              next_s.state = ST_IDLE; // R2
            end else begin
              next_s.state = ST_DATA;
            end
          end
        end
        // Data: one voted bit per bit period, LSB first
        ST_DATA: begin
          if (at_decide) begin
            next_s.receive_shift_register =
              {bit_val, s.receive_shift_register[8:1]}; // R3
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt + 4'h1 == char_bits(s.nine_bit_receive_select)) begin
              next_s.state = ST_STOP; // R15
            end
          end
        end
        // Stop: sample the stop level and hand the character over
        ST_STOP: begin
          if (at_decide) begin
            next_s.state = ST_IDLE;
            deliver = 1'b1; // R5
            entry = pack_entry(bit_val, s.nine_bit_receive_select,
                               s.receive_shift_register); // R4 R10
          end
        end
      endcase
    end

    // Address filter
    if (!admitted(s.nine_bit_receive_select, s.address_detect_enable,
                  entry)) begin
      deliver = 1'b0; // R17
    end

    // Two-entry buffer, oldest in slot 0
    left = s.count;
    if (pop) begin
      next_s.entries[0] = s.entries[1];
      next_s.entries[1] = 10'h000;
      left = s.count - 2'h1;
    end
    // Overrun is judged after a same-cycle read frees a slot
    if (deliver & ~s.overrun_error_flag) begin // R13
      if (left == BUF_DEPTH) begin
        next_s.overrun_error_flag = 1'b1; // R12
      end else if (left == 2'h1) begin
        next_s.entries[1] = entry;
        left = BUF_DEPTH;
      end else begin
        next_s.entries[0] = entry;
        left = 2'h1;
      end
    end
    next_s.count = left;

    // Receive-enable clear drops overrun but keeps data and framing
    if (!s.continuous_receive_enable) begin
      next_s.overrun_error_flag = 1'b0; // R14
    end
    // Port disable is last so it wins over every other update
    if (!s.port_enable) begin
      next_s.overrun_error_flag = 1'b0; // R22
      next_s.count = 2'h0;
      next_s.entries = '0; // R11
      next_s.state = ST_IDLE;
    end
  end

  // All state in one register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.baud_divisor <= BAUD_DEFAULT;
      s.state <= ST_IDLE;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  // No wait states: every access completes in its first cycle
  assign pready = 1'b1;
  assign pslverr = access & unmapped;
  // Flag ignores the interrupt enables; only the request is gated
  assign receive_flag = flag;
  assign interrupt_request = flag & s.receive_interrupt_enable &
                             s.peripheral_interrupt_enable &
                             s.global_interrupt_enable; // R8

endmodule : asr_receiver

// ---- verification/asr_line_tx.sv ----
// Behavioural remote transmitter on the receive line
`timescale 1ns/10ps
module asr_line_tx (
  // Clock and request
  input wire logic clk,
  input wire logic go,
  input wire logic [8:0] word,
  input wire logic nine,
  input wire logic stop_lvl,
  input wire logic glitch,
  // Line
  output logic line,
  output logic busy
);
  task automatic put(input logic b, input int n);
    line <= b;
    repeat (n) @(posedge clk);
  endtask : put
  initial begin
    line = 1'h1;
    busy = 1'h0;
  end
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'h1;
      put(1'h0, glitch ? 4 : 16);
      if (!glitch) begin
        for (int i = 0; i < (nine ? 9 : 8); i++) put(word[i], 16);
        put(stop_lvl, 16);
      end
      line <= 1'h1;
      busy <= 1'h0;
    end
  end
endmodule : asr_line_tx

// ---- verification/asr_receiver_properties.sv ----
// Port-level properties of the serial receiver
`timescale 1ns/10ps
module asr_receiver_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and flags
  input wire logic rx_line,
  input wire logic receive_flag,
  input wire logic interrupt_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [8:0] since_low;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_low <= 9'h1FF;
    else if (!rx_line) since_low <= 9'h000;
    else if (since_low != 9'h1FF) since_low <= since_low + 9'h001;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_wr_done; $past(psel && penable && pwrite) ||
    $past(psel && penable && pwrite, 2);
  endsequence
  property p_ready; s_access |-> pready; endproperty
  property p_no_err; !psel |-> !pslverr; endproperty
  property p_map_ok;
    psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_map_bad; psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  property p_stands; !(psel && !penable) |=> $stable(prdata); endproperty
  property p_irq; interrupt_request |-> receive_flag; endproperty
  property p_rise; $rose(receive_flag) |-> since_low < 9'h0C8 or s_wr_done;
  endproperty
  property p_fall;
    $fell(receive_flag) |-> $past(psel && penable) ||
      $past(psel && penable, 2);
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_no_err: assert property (p_no_err) else $error("idle slverr");
  a_map_ok: assert property (p_map_ok) else $error("bad slverr");
  a_map_bad: assert property (p_map_bad) else $error("no slverr");
  a_stands: assert property (p_stands) else $error("prdata moved");
  a_irq: assert property (p_irq) else $error("irq w/o flag");
  a_rise: assert property (p_rise) else $error("flag rose");
  a_fall: assert property (p_fall) else $error("flag fell");
endmodule : asr_receiver_properties
bind asr_receiver asr_receiver_properties u_props (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .receive_flag(receive_flag),
  .interrupt_request(interrupt_request));

// ---- verification/asr_receiver_tb_top.sv ----
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
module asr_receiver_tb_top
  import asr_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, go = 1'h0, nine = 1'h0, stop_lvl = 1'h1;
  logic glitch = 1'h0, pready, pslverr, rx_line, receive_flag;
  logic interrupt_request, busy, rd_err;
  logic [7:0] paddr = 8'h00;
  logic [8:0] word = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  int num_errors = 0, samples_checked = 0;
  // Sent byte, stop level, expected data, expected status
  logic [24:0] rows [4] = '{{8'hA5, 1'h1, 8'hA5, 8'h90},
    {8'h00, 1'h0, 8'h00, 8'h94}, {8'hFF, 1'h1, 8'hFF, 8'h90},
    {8'h3C, 1'h0, 8'h3C, 8'h94}};
  always #2.5 pclk = ~pclk;
  asr_receiver uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .receive_flag(receive_flag), .interrupt_request(interrupt_request));
  asr_line_tx u_tx (.clk(pclk), .go(go), .word(word), .nine(nine),
    .stop_lvl(stop_lvl), .glitch(glitch), .line(rx_line), .busy(busy));
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) num_errors++;
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(what, rd_val, e);
  endtask : rchk
  task automatic pins(input logic f, input logic i);
    repeat (2) @(posedge pclk);
    chk("flag", {31'h0, receive_flag}, {31'h0, f});
    chk("irq", {31'h0, interrupt_request}, {31'h0, i});
  endtask : pins
  task automatic send(input logic [8:0] w, input logic s, input logic g);
    int n;
    n = 0;
    @(posedge pclk);
    word <= w;
    stop_lvl <= s;
    glitch <= g;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    repeat (2) @(posedge pclk);
    while (busy && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) num_errors++;
    repeat (12) @(posedge pclk);
  endtask : send
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rchk("ctrl", OFF_CTRL, 32'h0);
    rchk("baud", OFF_BAUD, 32'h0);
    wr(OFF_BAUD, 32'h0);
    wr(OFF_INTC, 32'hC0);
    wr(OFF_IEN, 32'h20);
    wr(OFF_CTRL, 32'h90);
    send(9'h000, 1'h1, 1'h1);
    pins(1'h0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      send({1'h0, rows[i][24:17]}, rows[i][16], 1'h0);
      pins(1'h1, 1'h1);
      rchk("stat", OFF_CTRL, {24'h0, rows[i][7:0]});
      rchk("data", OFF_DATA, {24'h0, rows[i][15:8]});
      pins(1'h0, 1'h0);
    end
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", {31'h0, rd_err}, 32'h1);
    wr(OFF_FLAG, 32'h20);
    pins(1'h0, 1'h0);
    for (int i = 1; i < 5; i++) send({1'h0, 4'(i), 4'(i)}, 1'h1, 1'h0);
    rchk("ovr", OFF_CTRL, 32'h92);
    wr(OFF_INTC, 32'h80);
    pins(1'h1, 1'h0);
    wr(OFF_INTC, 32'hC0);
    rchk("d1", OFF_DATA, 32'h11);
    rchk("d2", OFF_DATA, 32'h22);
    pins(1'h0, 1'h0);
    wr(OFF_CTRL, 32'h80);
    rchk("oclr", OFF_CTRL, 32'h80);
    wr(OFF_CTRL, 32'h90);
    send(9'h05A, 1'h0, 1'h0);
    wr(OFF_CTRL, 32'h80);
    rchk("keep", OFF_CTRL, 32'h84);
    pins(1'h0, 1'h0);
    wr(OFF_CTRL, 32'h00);
    rchk("fclr", OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'hD8);
    pins(1'h0, 1'h0);
    nine <= 1'h1;
    send(9'h055, 1'h1, 1'h0);
    pins(1'h0, 1'h0);
    send(9'h1A7, 1'h1, 1'h0);
    rchk("n9", OFF_CTRL, 32'hD9);
    rchk("adr", OFF_DATA, 32'hA7);
    wr(OFF_CTRL, 32'hD0);
    send(9'h03C, 1'h1, 1'h0);
    rchk("n0", OFF_CTRL, 32'hD0);
    rchk("d9", OFF_DATA, 32'h3C);
    send(9'h1C3, 1'h1, 1'h0);
    pins(1'h1, 1'h1);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    pins(1'h0, 1'h0);
    rchk("rst", OFF_CTRL, 32'h0);
    stop_test;
  end
endmodule : asr_receiver_tb_top
